//--- design/timer16_core.sv
// Sixteen-bit timer core with byte-wide io access through a shared temp byte
`timescale 1ns/10ps
module timer16_core (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Byte-wide io access
  input wire logic [5:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic io_write_i,
  input wire logic io_read_i,
  output logic [7:0] io_rdata_o,
  // Control bits
  input wire logic [2:0] clock_select_i,
  input wire logic clear_on_compare_a_i,
  input wire logic [1:0] pwm_mode_i,
  input wire logic capture_rising_i,
  // Flag clear, vector acknowledge or write of one
  input wire logic [3:0] flag_clear_i,
  // Pins
  input wire logic external_count_pin_i,
  input wire logic capture_input_pin_i,
  // Status
  output logic [3:0] flags_o,
  output logic [15:0] counter_value_o,
  output logic compare_a_match_o,
  output logic compare_b_match_o
);

  typedef struct packed {
    logic [15:0] counter;
    logic [15:0] compare_a;
    logic [15:0] compare_b;
    logic [15:0] capture;
    logic [7:0] temp;
    logic [7:0] rdata;
    timer16_pkg::count_dir_type dir;
    logic match_a_pend;
    logic match_b_pend;
    logic [3:0] flags;
    logic cap_meta;
    logic cap_sync;
    logic cap_prev;
  } core_state_type;

  core_state_type st;
  core_state_type next_st;

  logic tick;
  logic pwm_on;
  logic [15:0] pwm_top;
  logic wr_count_low;
  logic wr_count_high;
  logic wr_cmp_a_low;
  logic wr_cmp_b_low;
  logic wr_any_high;
  logic rd_count_low;
  logic rd_capture_low;
  logic ctc_clear;
  logic cap_edge;
  logic [15:0] counted;
  logic [3:0] flag_set;

  timer16_tick_gen u_tick_gen (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .clock_select_i(clock_select_i),
    .external_count_pin_i(external_count_pin_i),
    .tick_o(tick)
  );

  function automatic logic io_hit(input logic strobe,
                                  input logic [5:0] addr,
                                  input logic [5:0] target);
    io_hit = strobe && (addr == target);
  endfunction

  always_comb begin
    case (pwm_mode_i)
      timer16_pkg::PWM_8BIT: pwm_top = timer16_pkg::TOP_8BIT;
      timer16_pkg::PWM_9BIT: pwm_top = timer16_pkg::TOP_9BIT;
      timer16_pkg::PWM_10BIT: pwm_top = timer16_pkg::TOP_10BIT;
      default: pwm_top = timer16_pkg::COUNT_MAX;
    endcase
  end

  assign pwm_on = pwm_mode_i != timer16_pkg::PWM_OFF;
  assign wr_count_low = io_hit(io_write_i, io_addr_i,
                               timer16_pkg::ADDR_COUNT_LOW);
  assign wr_count_high = io_hit(io_write_i, io_addr_i,
                                timer16_pkg::ADDR_COUNT_HIGH);
  assign wr_cmp_a_low = io_hit(io_write_i, io_addr_i,
                               timer16_pkg::ADDR_COMPARE_A_LOW);
  assign wr_cmp_b_low = io_hit(io_write_i, io_addr_i,
                               timer16_pkg::ADDR_COMPARE_B_LOW);
  assign wr_any_high = wr_count_high
    || io_hit(io_write_i, io_addr_i, timer16_pkg::ADDR_COMPARE_A_HIGH)
    || io_hit(io_write_i, io_addr_i, timer16_pkg::ADDR_COMPARE_B_HIGH);
  assign rd_count_low = io_hit(io_read_i, io_addr_i,
                               timer16_pkg::ADDR_COUNT_LOW);
  assign rd_capture_low = io_hit(io_read_i, io_addr_i,
                                 timer16_pkg::ADDR_CAPTURE_LOW);
  assign ctc_clear = st.match_a_pend && clear_on_compare_a_i
    && !pwm_on;
  assign cap_edge = capture_rising_i ? (!st.cap_prev && st.cap_sync)
                                     : (st.cap_prev && !st.cap_sync);

  // Next count value on a tick, up or up/down
  always_comb begin
    counted = st.counter;
    if (!pwm_on) begin
      counted = st.counter + timer16_pkg::COUNT_ONE;
    end else if (st.dir == timer16_pkg::DIR_UP) begin
      if (st.counter >= pwm_top) begin
        counted = st.counter - timer16_pkg::COUNT_ONE;
      end else begin
        counted = st.counter + timer16_pkg::COUNT_ONE;
      end
    end else begin
      if (st.counter == timer16_pkg::COUNT_ZERO) begin
        counted = st.counter + timer16_pkg::COUNT_ONE;
      end else begin
        counted = st.counter - timer16_pkg::COUNT_ONE;
      end
    end
  end

  always_comb begin
    next_st = st;
    flag_set = timer16_pkg::FLAGS_NONE;
    next_st.match_a_pend = 1'b0;
    next_st.match_b_pend = 1'b0;
    next_st.cap_meta = capture_input_pin_i;
    next_st.cap_sync = st.cap_meta;
    next_st.cap_prev = st.cap_sync;

    // Match is registered, so flags land one cycle after the event
    flag_set[timer16_pkg::FLAG_COMPARE_A] = st.match_a_pend;
    flag_set[timer16_pkg::FLAG_COMPARE_B] = st.match_b_pend;

    if (tick) begin
      next_st.counter = counted;
      if (pwm_on) begin
        if (st.dir == timer16_pkg::DIR_UP && st.counter >= pwm_top) begin
          next_st.dir = timer16_pkg::DIR_DOWN;
        end else if (st.counter == timer16_pkg::COUNT_ZERO) begin
          next_st.dir = timer16_pkg::DIR_UP;
          flag_set[timer16_pkg::FLAG_OVERFLOW] = 1'b1;
        end
      end else if (st.counter == timer16_pkg::COUNT_MAX) begin
        flag_set[timer16_pkg::FLAG_OVERFLOW] = 1'b1;
      end
      next_st.match_a_pend = counted == st.compare_a;
      next_st.match_b_pend = counted == st.compare_b;
    end

    // One cycle late, hence a prescaled period shorter above divide by one
    if (ctc_clear) begin
      next_st.counter = timer16_pkg::COUNT_ZERO;
      next_st.match_a_pend = 1'b0;
      next_st.match_b_pend = 1'b0;
      if (!tick) begin
        flag_set[timer16_pkg::FLAG_OVERFLOW] = 1'b0;
      end
    end

    if (cap_edge) begin
      next_st.capture = st.counter;
      flag_set[timer16_pkg::FLAG_CAPTURE] = 1'b1;
    end

    // Set wins over a clear in the same cycle
    next_st.flags = (st.flags & ~flag_clear_i) | flag_set;

    // Temp byte is shared, so interleaved accesses corrupt each other
    if (wr_any_high) begin
      next_st.temp = io_wdata_i;
    end
    if (wr_count_low) begin
      next_st.counter = {st.temp, io_wdata_i};
      next_st.match_a_pend = 1'b0;
      next_st.match_b_pend = 1'b0;
    end
    if (wr_cmp_a_low) begin
      next_st.compare_a = {st.temp, io_wdata_i};
    end
    if (wr_cmp_b_low) begin
      next_st.compare_b = {st.temp, io_wdata_i};
    end

    if (io_read_i) begin
      case (io_addr_i)
        timer16_pkg::ADDR_COUNT_LOW: begin
          next_st.rdata = st.counter[7:0];
          next_st.temp = st.counter[15:8];
        end
        timer16_pkg::ADDR_CAPTURE_LOW: begin
          next_st.rdata = st.capture[7:0];
          next_st.temp = st.capture[15:8];
        end
        timer16_pkg::ADDR_COUNT_HIGH: next_st.rdata = st.temp;
        timer16_pkg::ADDR_CAPTURE_HIGH: next_st.rdata = st.temp;
        timer16_pkg::ADDR_COMPARE_A_LOW: next_st.rdata = st.compare_a[7:0];
        timer16_pkg::ADDR_COMPARE_A_HIGH:
          next_st.rdata = st.compare_a[15:8];
        timer16_pkg::ADDR_COMPARE_B_LOW: next_st.rdata = st.compare_b[7:0];
        timer16_pkg::ADDR_COMPARE_B_HIGH:
          next_st.rdata = st.compare_b[15:8];
        default: next_st.rdata = timer16_pkg::BYTE_ZERO;
      endcase
    end
  end

  // Capture has no write path at all
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign io_rdata_o = st.rdata;
  assign flags_o = st.flags;
  assign counter_value_o = st.counter;
  assign compare_a_match_o = st.match_a_pend;
  assign compare_b_match_o = st.match_b_pend;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_count_to_a;
    tick && !pwm_on && !ctc_clear && !wr_count_low
      && (counted == st.compare_a);
  endsequence

  sequence s_match_a_then_flag;
    st.match_a_pend ##1 st.flags[timer16_pkg::FLAG_COMPARE_A];
  endsequence

  sequence s_ctc_armed;
    st.match_a_pend && clear_on_compare_a_i && !pwm_on && !wr_count_low;
  endsequence

  sequence s_low_read;
    rd_count_low && !wr_any_high;
  endsequence

  AST_CTC_CLEAR: assert property (
    s_count_to_a ##1 s_ctc_armed |=> st.counter == timer16_pkg::COUNT_ZERO)
    else $error("counter not cleared after compare A match");

  AST_NO_CTC: assert property (
    st.match_a_pend && !clear_on_compare_a_i && !pwm_on && tick
      && !wr_count_low
      |=> st.counter == $past(st.counter) + timer16_pkg::COUNT_ONE)
    else $error("counter disturbed by match without clear option");

  AST_PWM_IGNORES_CTC: assert property (
    st.match_a_pend && clear_on_compare_a_i && pwm_on && !wr_count_low
      |=> st.counter == ($past(tick) ? $past(counted) : $past(st.counter)))
    else $error("clear option acted in PWM mode");

  AST_STOPPED: assert property (
    clock_select_i == timer16_pkg::CS_STOP && !wr_count_low && !ctc_clear
      |=> $stable(st.counter))
    else $error("counter moved while stopped");

  AST_COUNT_WRITE: assert property (
    wr_count_low |=> st.counter == {$past(st.temp), $past(io_wdata_i)})
    else $error("counter low write did not load both bytes");

  AST_COUNT_READ: assert property (
    s_low_read ##1 (!io_read_i && !io_write_i)
      ##1 (io_read_i && io_addr_i == timer16_pkg::ADDR_COUNT_HIGH)
      |=> io_rdata_o == $past(st.counter[15:8], 3))
    else $error("high byte read did not return latched byte");

  AST_MATCH_FROM_COUNT: assert property (
    s_count_to_a |=> st.match_a_pend)
    else $error("count to compare A gave no match");

  AST_WRITE_NO_MATCH: assert property (
    wr_count_low |=> !st.match_a_pend && !st.match_b_pend)
    else $error("software write produced a match");

  AST_FLAG_A: assert property (
    st.match_a_pend |-> s_match_a_then_flag)
    else $error("compare A flag not set one cycle after match");

  AST_CMP_WRITE: assert property (
    wr_cmp_b_low |=> st.compare_b == {$past(st.temp), $past(io_wdata_i)})
    else $error("compare B low write did not update both bytes");

  AST_CAPTURE: assert property (
    cap_edge |=> st.capture == $past(st.counter)
      && st.flags[timer16_pkg::FLAG_CAPTURE])
    else $error("capture edge did not latch counter and flag");

  AST_OVERFLOW: assert property (
    tick && !pwm_on && !wr_count_low && !ctc_clear
      && st.counter == timer16_pkg::COUNT_MAX
      |=> st.flags[timer16_pkg::FLAG_OVERFLOW]
        && st.counter == timer16_pkg::COUNT_ZERO)
    else $error("wrap did not set overflow flag");

  AST_CAP_CLEAR: assert property (
    flag_clear_i[timer16_pkg::FLAG_CAPTURE] && !cap_edge
      |=> !st.flags[timer16_pkg::FLAG_CAPTURE])
    else $error("capture flag not cleared");

  AST_FLAG_B: assert property (
    st.match_b_pend |=> st.flags[timer16_pkg::FLAG_COMPARE_B])
    else $error("compare B flag not set one cycle after match");

  AST_NO_MATCH_IDLE: assert property (
    !tick |=> !st.match_a_pend && !st.match_b_pend)
    else $error("match without a counting tick");

  AST_UP_COUNT: assert property (
    tick && !pwm_on && !wr_count_low && !ctc_clear
      |=> st.counter == $past(st.counter) + timer16_pkg::COUNT_ONE)
    else $error("counter did not step up on a tick");

  AST_PWM_TURN: assert property (
    tick && pwm_on && st.dir == timer16_pkg::DIR_UP
      && st.counter == pwm_top && !wr_count_low
      |=> st.counter == $past(pwm_top) - timer16_pkg::COUNT_ONE
        && st.dir == timer16_pkg::DIR_DOWN)
    else $error("counter did not turn down at top");

  AST_PWM_OVERFLOW: assert property (
    tick && pwm_on && st.counter == timer16_pkg::COUNT_ZERO
      && !wr_count_low
      |=> st.flags[timer16_pkg::FLAG_OVERFLOW]
        && st.counter == timer16_pkg::COUNT_ONE)
    else $error("leaving zero in PWM mode did not set overflow");

  AST_CAPTURE_HOLD: assert property (
    !cap_edge |=> $stable(st.capture))
    else $error("capture register changed without a capture edge");

  AST_CAPTURE_READ: assert property (
    rd_capture_low |=> st.temp == $past(st.capture[15:8])
      && io_rdata_o == $past(st.capture[7:0]))
    else $error("capture low read did not park high byte in temp");

  AST_TEMP_WRITE: assert property (
    wr_any_high && !io_read_i |=> st.temp == $past(io_wdata_i))
    else $error("high byte write did not land in temp");

  AST_CMP_A_WRITE: assert property (
    wr_cmp_a_low |=> st.compare_a == {$past(st.temp), $past(io_wdata_i)})
    else $error("compare A low write did not update both bytes");

  AST_CMP_READ: assert property (
    io_read_i && io_addr_i == timer16_pkg::ADDR_COMPARE_B_HIGH
      |=> io_rdata_o == $past(st.compare_b[15:8]))
    else $error("compare B high byte read wrong");

  AST_CAP_STICKY: assert property (
    st.flags[timer16_pkg::FLAG_CAPTURE]
      && !flag_clear_i[timer16_pkg::FLAG_CAPTURE]
      |=> st.flags[timer16_pkg::FLAG_CAPTURE])
    else $error("capture flag lost without a clear");

endmodule // timer16_core

//--- design/timer16_pkg.sv
// Constants and types shared by the sixteen-bit timer core
package timer16_pkg;

  // Byte addresses of the io window
  localparam logic [5:0] ADDR_CAPTURE_LOW = 6'h26;
  localparam logic [5:0] ADDR_CAPTURE_HIGH = 6'h27;
  localparam logic [5:0] ADDR_COMPARE_B_LOW = 6'h28;
  localparam logic [5:0] ADDR_COMPARE_B_HIGH = 6'h29;
  localparam logic [5:0] ADDR_COMPARE_A_LOW = 6'h2a;
  localparam logic [5:0] ADDR_COMPARE_A_HIGH = 6'h2b;
  localparam logic [5:0] ADDR_COUNT_LOW = 6'h2c;
  localparam logic [5:0] ADDR_COUNT_HIGH = 6'h2d;

  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  localparam int PRESCALE_WIDTH = 10;
  localparam logic [9:0] PRESCALE_ZERO = 10'h000;
  localparam logic [9:0] PRESCALE_ONE = 10'h001;
  localparam logic [9:0] MASK_DIV8 = 10'h007;
  localparam logic [9:0] MASK_DIV64 = 10'h03f;
  localparam logic [9:0] MASK_DIV256 = 10'h0ff;
  localparam logic [9:0] MASK_DIV1024 = 10'h3ff;

  // PWM resolution select
  localparam logic [1:0] PWM_OFF = 2'h0;
  localparam logic [1:0] PWM_8BIT = 2'h1;
  localparam logic [1:0] PWM_9BIT = 2'h2;
  localparam logic [1:0] PWM_10BIT = 2'h3;

  // Flag bit positions
  localparam int FLAG_OVERFLOW = 0;
  localparam int FLAG_COMPARE_B = 1;
  localparam int FLAG_COMPARE_A = 2;
  localparam int FLAG_CAPTURE = 3;
  localparam logic [3:0] FLAGS_NONE = 4'h0;

  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } count_dir_type;

endpackage

//--- design/timer16_tick_gen.sv
// Prescaler and external count pin edge detector for the timer core
`timescale 1ns/10ps
module timer16_tick_gen (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Source select
  input wire logic [2:0] clock_select_i,
  // Pin
  input wire logic external_count_pin_i,
  // Count enable for the counter
  output logic tick_o
);

  typedef struct packed {
    logic [timer16_pkg::PRESCALE_WIDTH-1:0] prescale;
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
  } tick_state_type;

  tick_state_type st;
  tick_state_type next_st;

  function automatic logic div_done(input logic [9:0] cnt,
                                    input logic [9:0] mask);
    div_done = (cnt & mask) == mask;
  endfunction

  // Prescaler free-runs so every division stays phase locked to the clock
  always_comb begin
    next_st = st;
    next_st.prescale = st.prescale + timer16_pkg::PRESCALE_ONE;
    next_st.pin_meta = external_count_pin_i;
    next_st.pin_sync = st.pin_meta;
    next_st.pin_prev = st.pin_sync;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    case (clock_select_i)
      timer16_pkg::CS_STOP: tick_o = 1'b0;
      timer16_pkg::CS_DIV1: tick_o = 1'b1;
      timer16_pkg::CS_DIV8:
        tick_o = div_done(st.prescale, timer16_pkg::MASK_DIV8);
      timer16_pkg::CS_DIV64:
        tick_o = div_done(st.prescale, timer16_pkg::MASK_DIV64);
      timer16_pkg::CS_DIV256:
        tick_o = div_done(st.prescale, timer16_pkg::MASK_DIV256);
      timer16_pkg::CS_DIV1024:
        tick_o = div_done(st.prescale, timer16_pkg::MASK_DIV1024);
      timer16_pkg::CS_EXT_FALL: tick_o = st.pin_prev && !st.pin_sync;
      timer16_pkg::CS_EXT_RISE: tick_o = !st.pin_prev && st.pin_sync;
      default: tick_o = 1'b0;
    endcase
  end

endmodule // timer16_tick_gen

//--- testbench/timer16_cpu_model.sv
// CPU-side model: byte io accesses to the timer and its two pins
`timescale 1ns/10ps
module timer16_cpu_model (
  // Clock
  input wire logic ref_clk_i,
  // Io bus towards the timer
  output logic [5:0] io_addr_o,
  output logic [7:0] io_wdata_o,
  output logic io_write_o,
  output logic io_read_o,
  input wire logic [7:0] io_rdata_i,
  // Pins, driven as inputs of the timer
  output logic ext_pin_o,
  output logic cap_pin_o
);
  initial begin
    io_addr_o = 6'h00;
    io_wdata_o = 8'h00;
    io_write_o = 1'b0;
    io_read_o = 1'b0;
    ext_pin_o = 1'b0;
    cap_pin_o = 1'b0;
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    io_addr_o <= a;
    io_wdata_o <= d;
    io_write_o <= 1'b1;
    @(posedge ref_clk_i);
    io_write_o <= 1'b0;
    // Released data bus never shows the old byte
    io_wdata_o <= ~d;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    io_addr_o <= a;
    io_read_o <= 1'b1;
    @(posedge ref_clk_i);
    io_read_o <= 1'b0;
    #1;
    d = io_rdata_i;
  endtask

  // Pairs are never split by another temp access
  task automatic wr16(input logic [5:0] a_low, input logic [15:0] v);
    wr(a_low + 6'h01, v[15:8]);
    wr(a_low, v[7:0]);
  endtask

  task automatic rd16(input logic [5:0] a_low, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a_low, lo);
    rd(a_low + 6'h01, hi);
    v = {hi, lo};
  endtask

  // Slow pin changes, well past the synchroniser
  task automatic set_ext(input logic v);
    @(posedge ref_clk_i);
    ext_pin_o <= v;
    repeat (8) @(posedge ref_clk_i);
  endtask

  task automatic set_cap(input logic v);
    @(posedge ref_clk_i);
    cap_pin_o <= v;
    repeat (8) @(posedge ref_clk_i);
  endtask
endmodule // timer16_cpu_model

//--- testbench/sixteen_bit_timer_core_tb_top.sv
// Self-checking bench for the sixteen-bit timer core
`timescale 1ns/10ps
`define CHK(got, exp) chk(16'(got), 16'(exp))
module sixteen_bit_timer_core_tb_top;
  logic ref_clk_i;
  logic rst_b_i;
  logic [5:0] io_addr;
  logic [7:0] io_wdata;
  logic io_write;
  logic io_read;
  logic [7:0] io_rdata;
  logic [2:0] clock_select;
  logic ctc;
  logic [1:0] pwm_mode;
  logic cap_rising;
  logic [3:0] flag_clear;
  logic ext_pin;
  logic cap_pin;
  logic [3:0] flags_o;
  logic [15:0] counter_value_o;
  logic compare_a_match_o;
  logic compare_b_match_o;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  int divs [5] = '{1, 8, 64, 256, 1024};

  timer16_core uut (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .io_addr_i(io_addr),
    .io_wdata_i(io_wdata),
    .io_write_i(io_write),
    .io_read_i(io_read),
    .io_rdata_o(io_rdata),
    .clock_select_i(clock_select),
    .clear_on_compare_a_i(ctc),
    .pwm_mode_i(pwm_mode),
    .capture_rising_i(cap_rising),
    .flag_clear_i(flag_clear),
    .external_count_pin_i(ext_pin),
    .capture_input_pin_i(cap_pin),
    .flags_o(flags_o),
    .counter_value_o(counter_value_o),
    .compare_a_match_o(compare_a_match_o),
    .compare_b_match_o(compare_b_match_o)
  );

  timer16_cpu_model cpu (
    .ref_clk_i(ref_clk_i),
    .io_addr_o(io_addr),
    .io_wdata_o(io_wdata),
    .io_write_o(io_write),
    .io_read_o(io_read),
    .io_rdata_i(io_rdata),
    .ext_pin_o(ext_pin),
    .cap_pin_o(cap_pin)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Bounded wait: 0 match A, 1 match B, 2 overflow flag
  task automatic wait_on(input int sel);
    int i;
    logic s;
    for (i = 0; i < 600; i++) begin
      @(posedge ref_clk_i);
      #1;
      s = (sel == 0) ? compare_a_match_o :
          (sel == 1) ? compare_b_match_o : flags_o[0];
      if (s === 1'b1) break;
    end
    if (i == 600) `CHK(1'b0, 1'b1);
  endtask

  task automatic clear_flags();
    @(posedge ref_clk_i);
    flag_clear <= 4'hf;
    @(posedge ref_clk_i);
    flag_clear <= 4'h0;
    #1;
  endtask

  task automatic run(input logic [2:0] cs, input int n);
    @(posedge ref_clk_i);
    clock_select <= cs;
    repeat (n) @(posedge ref_clk_i);
    clock_select <= timer16_pkg::CS_STOP;
    repeat (8) @(posedge ref_clk_i);
    #1;
  endtask

  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    logic [15:0] v;
    logic [7:0] b;
    rst_b_i = 1'b0;
    clock_select = timer16_pkg::CS_STOP;
    ctc = 1'b0;
    pwm_mode = timer16_pkg::PWM_OFF;
    cap_rising = 1'b1;
    flag_clear = 4'h0;
    repeat (8) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    for (int a = 'h26; a <= 'h2d; a++) begin
      cpu.rd(6'(a), b);
      `CHK(b, 8'h00);
    end
    cpu.rd(6'h10, b);
    `CHK(b, 8'h00);
    `CHK(flags_o, 4'h0);
    // Byte pairing of the counter, clock stopped
    cpu.wr(timer16_pkg::ADDR_COUNT_HIGH, 8'h5a);
    #1;
    `CHK(counter_value_o, 16'h0000);
    cpu.wr(timer16_pkg::ADDR_COUNT_LOW, 8'hc3);
    #1;
    `CHK(counter_value_o, 16'h5ac3);
    repeat (5) @(posedge ref_clk_i);
    cpu.rd16(timer16_pkg::ADDR_COUNT_LOW, v);
    `CHK(v, 16'h5ac3);
    cpu.wr16(timer16_pkg::ADDR_COMPARE_A_LOW, 16'h0010);
    cpu.wr(timer16_pkg::ADDR_COMPARE_A_HIGH, 8'h77);
    cpu.rd(timer16_pkg::ADDR_COMPARE_A_HIGH, b);
    `CHK(b, 8'h00);
    cpu.rd(timer16_pkg::ADDR_COMPARE_A_LOW, b);
    `CHK(b, 8'h10);
    cpu.wr16(timer16_pkg::ADDR_COMPARE_B_LOW, 16'h0020);
    cpu.wr16(timer16_pkg::ADDR_COUNT_LOW, 16'h0020);
    repeat (4) @(posedge ref_clk_i);
    #1;
    `CHK(flags_o, 4'h0);
    // Clear on compare A, single-cycle prescale
    cpu.wr16(timer16_pkg::ADDR_COUNT_LOW, 16'h000c);
    @(posedge ref_clk_i);
    ctc <= 1'b1;
    clock_select <= timer16_pkg::CS_DIV1;
    wait_on(0);
    `CHK(counter_value_o, 16'h0010);
    @(posedge ref_clk_i);
    #1;
    `CHK(counter_value_o, 16'h0000);
    `CHK(flags_o[timer16_pkg::FLAG_COMPARE_A], 1'b1);
    @(posedge ref_clk_i);
    ctc <= 1'b0;
    clock_select <= timer16_pkg::CS_STOP;
    clear_flags();
    `CHK(flags_o, 4'h0);
    cpu.wr16(timer16_pkg::ADDR_COUNT_LOW, 16'h000e);
    @(posedge ref_clk_i);
    clock_select <= timer16_pkg::CS_DIV1;
    wait_on(0);
    @(posedge ref_clk_i);
    #1;
    `CHK(counter_value_o, 16'h0011);
    wait_on(1);
    `CHK(counter_value_o, 16'h0020);
    @(posedge ref_clk_i);
    #1;
    `CHK(flags_o[timer16_pkg::FLAG_COMPARE_B], 1'b1);
    cpu.wr16(timer16_pkg::ADDR_COUNT_LOW, 16'hfffd);
    wait_on(2);
    `CHK(counter_value_o, 16'h0000);
    cpu.wr16(timer16_pkg::ADDR_COUNT_LOW, 16'h0100);
    #1;
    `CHK(counter_value_o, 16'h0100);
    @(posedge ref_clk_i);
    #1;
    `CHK(counter_value_o, 16'h0101);
    // Every prescale code over a window of four periods
    for (int k = 0; k < 5; k++) begin
      @(posedge ref_clk_i);
      clock_select <= timer16_pkg::CS_STOP;
      cpu.wr16(timer16_pkg::ADDR_COUNT_LOW, 16'h0000);
      run(3'(k + 1), 4 * divs[k]);
      `CHK(counter_value_o, 16'h0004);
    end
    for (int j = 0; j < 2; j++) begin
      cpu.wr16(timer16_pkg::ADDR_COUNT_LOW, 16'h0000);
      @(posedge ref_clk_i);
      clock_select <= (j == 0) ? timer16_pkg::CS_EXT_RISE :
                                 timer16_pkg::CS_EXT_FALL;
      repeat (3) begin
        cpu.set_ext(1'b1);
        cpu.set_ext(1'b0);
      end
      run(clock_select, 1);
      `CHK(counter_value_o, 16'h0003);
    end
    // Capture, read-only capture, shared temp byte
    clear_flags();
    cpu.wr16(timer16_pkg::ADDR_COUNT_LOW, 16'h1234);
    cpu.set_cap(1'b1);
    `CHK(flags_o[timer16_pkg::FLAG_CAPTURE], 1'b1);
    cpu.wr16(timer16_pkg::ADDR_CAPTURE_LOW, 16'hbeef);
    cpu.rd16(timer16_pkg::ADDR_CAPTURE_LOW, v);
    `CHK(v, 16'h1234);
    cpu.wr16(timer16_pkg::ADDR_COUNT_LOW, 16'h5678);
    cpu.rd(timer16_pkg::ADDR_CAPTURE_LOW, b);
    cpu.rd(timer16_pkg::ADDR_COUNT_HIGH, b);
    `CHK(b, 8'h12);
    clear_flags();
    `CHK(flags_o[timer16_pkg::FLAG_CAPTURE], 1'b0);
    @(posedge ref_clk_i);
    cap_rising <= 1'b0;
    cpu.set_cap(1'b0);
    cpu.rd16(timer16_pkg::ADDR_CAPTURE_LOW, v);
    `CHK(v, 16'h5678);
    // Up/down count with clear on compare ignored
    cpu.wr16(timer16_pkg::ADDR_COUNT_LOW, 16'h00fd);
    @(posedge ref_clk_i);
    pwm_mode <= timer16_pkg::PWM_8BIT;
    ctc <= 1'b1;
    run(timer16_pkg::CS_DIV1, 6);
    `CHK(counter_value_o, 16'h00fb);
    clear_flags();
    @(posedge ref_clk_i);
    clock_select <= timer16_pkg::CS_DIV1;
    wait_on(0);
    @(posedge ref_clk_i);
    #1;
    `CHK(counter_value_o, 16'h000f);
    wait_on(2);
    `CHK(counter_value_o, 16'h0001);
    // Turning points of the wider up/down resolutions
    @(posedge ref_clk_i);
    clock_select <= timer16_pkg::CS_STOP;
    pwm_mode <= timer16_pkg::PWM_9BIT;
    cpu.wr16(timer16_pkg::ADDR_COUNT_LOW, 16'h01fe);
    run(timer16_pkg::CS_DIV1, 3);
    `CHK(counter_value_o, 16'h01fd);
    @(posedge ref_clk_i);
    pwm_mode <= timer16_pkg::PWM_10BIT;
    cpu.wr16(timer16_pkg::ADDR_COUNT_LOW, 16'h0000);
    run(timer16_pkg::CS_DIV1, 1);
    cpu.wr16(timer16_pkg::ADDR_COUNT_LOW, 16'h03fe);
    run(timer16_pkg::CS_DIV1, 3);
    `CHK(counter_value_o, 16'h03fd);
    close_out();
  end
endmodule // sixteen_bit_timer_core_tb_top
